/* File: rtl/rsi_cfg.svh */
// Offsets, field positions, reset values and timing counts of the reset state initialiser
`ifndef RSI_CFG_SVH
`define RSI_CFG_SVH
`define RSI_ADDR_STATUS 8'h00
`define RSI_ADDR_RSTFLAG 8'h01
`define RSI_ADDR_WDTCTL 8'h02
`define RSI_ADDR_INTEN 8'h03
`define RSI_ADDR_TMRCTL 8'h04
`define RSI_ADDR_PDATA 8'h05
`define RSI_ADDR_PDIR 8'h06
`define RSI_ADDR_PPULL 8'h07
`define RSI_ADDR_PWAKE 8'h08
`define RSI_ADDR_SERMODE 8'h09
`define RSI_ADDR_SERCTL 8'h0A
`define RSI_ADDR_SERTO 8'h0B
`define RSI_ADDR_LASTRST 8'h0C
`define RSI_TMO_BIT 5
`define RSI_PWD_BIT 4
`define RSI_LVF_BIT 2
`define RSI_WCF_BIT 0
`define RSI_TMR_ON_BIT 3
`define RSI_SERMODE_BIT 0
`define RSI_WE_MSB 7
`define RSI_WE_LSB 3
`define RSI_WS_MSB 2
`define RSI_WE_DISABLE 5'h15
`define RSI_WE_ENABLE 5'h0A
`define RSI_WDTCTL_RST 8'h53
`define RSI_PDATA_RST 8'hFF
`define RSI_PDIR_RST 8'hFF
`define RSI_PPULL_RST 8'h00
`define RSI_PWAKE_RST 8'h00
`define RSI_INTEN_RST 8'h00
`define RSI_TMRCTL_RST 8'h00
`define RSI_SIFCTL_RST 8'h81
`define RSI_ASCTL_RST 8'h00
`define RSI_SIFTO_RST 8'h00
`define RSI_BAUD_RST 8'h00
`define RSI_CLK_PERIOD_NS 100
`define RSI_T_SRESET_NS 1000
`define RSI_SRESET_CYCLES ((`RSI_T_SRESET_NS + `RSI_CLK_PERIOD_NS - 1) / `RSI_CLK_PERIOD_NS)
`define RSI_WDT_BASE_SHIFT 8
`endif

/* File: rtl/rsi_pkg.sv */
// Types shared by the reset state initialiser
package rsi_pkg;
  typedef enum logic [1:0] {
    RSI_MODE_FAST = 2'b00,
    RSI_MODE_SLOW = 2'b01,
    RSI_MODE_IDLE = 2'b10,
    RSI_MODE_SLEEP = 2'b11
  } rsi_mode_type;
  typedef enum logic [2:0] {
    RSI_KIND_POR = 3'b000,
    RSI_KIND_LVR = 3'b001,
    RSI_KIND_WDT_RUN = 3'b010,
    RSI_KIND_WDT_SLEEP = 3'b011,
    RSI_KIND_SOFT = 3'b100
  } rsi_kind_type;
endpackage : rsi_pkg

/* File: rtl/rsi_sync2.sv */
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/100ps
module rsi_sync2 (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : rsi_sync2

/* File: rtl/rsi_delay.sv */
// One-shot delay: pulses done a fixed number of cycles after start
`timescale 1ns/100ps
module rsi_delay #(
  parameter int CYCLES = 10
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic start,
  output logic done
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_reg;
  logic busy_reg;

  if (CYCLES < 1) begin : g_bad_cycles
    $error("rsi_delay: CYCLES must be at least 1");
  end

  // Restarting while busy is ignored: the first request sets the moment
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!busy_reg && start) begin
        busy_reg <= 1'b1;
        cnt_reg <= CW'(CYCLES - 1);
        if (CYCLES == 1) begin
          busy_reg <= 1'b0;
          done <= 1'b1;
        end
      end else if (busy_reg) begin
        if (cnt_reg == CW'(1)) begin
          busy_reg <= 1'b0;
          done <= 1'b1;
        end
        cnt_reg <= cnt_reg - CW'(1);
      end
    end
  end
endmodule : rsi_delay

/* File: rtl/rsi_core.sv */
// Reset state initialiser: reset sources, flags and register defaults
//
// How it works
// - Sleep or idle watchdog expiry clears program counter and stack pointer, sets timeout flag.
// - Timeout and powerdown flags live in status; power-on clears both.
// - Low-voltage reset in run modes leaves both flags unchanged.
// - Run-mode watchdog reset sets timeout flag, powerdown flag unchanged.
// - Idle or sleep watchdog reset sets both flags.
// - Power-on clears every interrupt enable.
// - Power-on clears watchdog and time-base counters; watchdog then counts at once.
// - Power-on leaves the timer module off.
// - Power-on makes pins inputs: data and direction all ones, pull and wake zero.
// - Power-on puts stack pointer at top and program counter at zero.
// - Full resets reload register defaults; sleep watchdog expiry preserves them.
// - Serial control pair and timeout/baud pair share addresses, mode bit selects.
// - Low-voltage reset sets its flag; only software or power-on clears it.
// - Illegal watchdog enable code resets after a delay, sets a software-cleared flag.
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`include "rsi_cfg.svh"
module rsi_core import rsi_pkg::*; #(
  parameter int WDT_BASE_SHIFT = `RSI_WDT_BASE_SHIFT,
  parameter int SRESET_CYCLES = `RSI_SRESET_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [1:0] core_mode,
  input wire logic halt_exec,
  input wire logic wdt_clear,
  input wire logic supply_low,
  output logic restart_pulse,
  output logic stack_to_top,
  output logic [7:0] int_enable,
  output logic timer_on,
  output logic [7:0] port_data,
  output logic [7:0] port_dir,
  output logic [7:0] port_pull,
  output logic [7:0] port_wake,
  output logic [7:0] time_base
);
  localparam int CNT_W = WDT_BASE_SHIFT + 8;

  if (WDT_BASE_SHIFT < 1 || WDT_BASE_SHIFT > 20 || SRESET_CYCLES < 1) begin : g_bad_param
    $error("rsi_core: WDT_BASE_SHIFT must be 1 to 20 and SRESET_CYCLES at least 1");
  end

  logic timeout_flag_reg;
  logic powerdown_flag_reg;
  logic low_voltage_reset_flag_reg;
  logic watchdog_ctrl_reset_flag_reg;
  logic [7:0] watchdog_control_reg;
  logic [7:0] int_en_reg;
  logic [7:0] tmr_ctl_reg;
  logic [7:0] pdata_reg;
  logic [7:0] pdir_reg;
  logic [7:0] ppull_reg;
  logic [7:0] pwake_reg;
  logic serial_mode_select_reg;
  logic [7:0] serial_iface_control_reg;
  logic [7:0] async_serial_control_reg;
  logic [7:0] serial_timeout_reg;
  logic [7:0] baud_rate_reg;
  logic [CNT_W-1:0] wdt_cnt_reg;
  logic [7:0] tb_cnt_reg;
  logic [2:0] last_kind_reg;
  logic lvr_prev_reg;
  logic por_first_reg;
  logic lvr_sync;
  logic soft_done;
  logic run_mode;
  logic ev_lvr;
  logic ev_wdt_run;
  logic ev_wdt_sleep;
  logic ev_soft;
  logic reload;
  logic any_event;
  logic wdt_expire;
  logic bad_we_write;
  logic [4:0] we_field;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit

  function automatic logic [CNT_W-1:0] wdt_limit(input logic [2:0] sel);
    logic [CNT_W:0] one;
    one = (CNT_W+1)'(1);
    return CNT_W'((one << (WDT_BASE_SHIFT + int'(sel))) - one);
  endfunction : wdt_limit

  rsi_sync2 u_lvr_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in(supply_low),
    .sync_out(lvr_sync)
  );

  rsi_delay #(.CYCLES(SRESET_CYCLES)) u_soft_delay (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(bad_we_write),
    .done(soft_done)
  );

  // Event detection; power-on is the async reset and so always wins
  assign run_mode = (core_mode == RSI_MODE_FAST) || (core_mode == RSI_MODE_SLOW);
  assign we_field = watchdog_control_reg[`RSI_WE_MSB:`RSI_WE_LSB];
  assign wdt_expire = (we_field != `RSI_WE_DISABLE) &&
                      (wdt_cnt_reg == wdt_limit(watchdog_control_reg[`RSI_WS_MSB:0]));
  assign ev_lvr = lvr_sync && !lvr_prev_reg && run_mode;
  assign ev_wdt_run = wdt_expire && run_mode && !ev_lvr;
  assign ev_wdt_sleep = wdt_expire && !run_mode;
  assign ev_soft = soft_done && !ev_lvr && !wdt_expire;
  assign reload = ev_lvr || ev_wdt_run || ev_soft;
  assign any_event = reload || ev_wdt_sleep;
  assign bad_we_write = reg_wr && hit(reg_addr, `RSI_ADDR_WDTCTL) &&
                        (reg_wdata[`RSI_WE_MSB:`RSI_WE_LSB] != `RSI_WE_DISABLE) &&
                        (reg_wdata[`RSI_WE_MSB:`RSI_WE_LSB] != `RSI_WE_ENABLE);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lvr_prev_reg <= 1'b0;
      por_first_reg <= 1'b1;
    end else begin
      lvr_prev_reg <= lvr_sync;
      por_first_reg <= 1'b0;
    end
  end

  // Status flags; the event sets last so it wins over a clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timeout_flag_reg <= 1'b0;
      powerdown_flag_reg <= 1'b0;
    end else begin
      if (wdt_clear) begin
        timeout_flag_reg <= 1'b0;
        powerdown_flag_reg <= 1'b0;
      end
      if (halt_exec) begin
        timeout_flag_reg <= 1'b0;
        powerdown_flag_reg <= 1'b1;
      end
      if (ev_wdt_run) begin
        timeout_flag_reg <= 1'b1;
      end
      if (ev_wdt_sleep) begin
        timeout_flag_reg <= 1'b1;
        powerdown_flag_reg <= 1'b1;
      end
    end
  end

  // Reset-source flags; software writes zero to clear, hardware set wins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      low_voltage_reset_flag_reg <= 1'b0;
      watchdog_ctrl_reset_flag_reg <= 1'b0;
    end else begin
      if (reg_wr && hit(reg_addr, `RSI_ADDR_RSTFLAG)) begin
        low_voltage_reset_flag_reg <= reg_wdata[`RSI_LVF_BIT];
        watchdog_ctrl_reset_flag_reg <= reg_wdata[`RSI_WCF_BIT];
      end
      if (ev_lvr) begin
        low_voltage_reset_flag_reg <= 1'b1;
      end
      if (ev_soft) begin
        watchdog_ctrl_reset_flag_reg <= 1'b1;
      end
    end
  end

  // Watchdog and time-base counters
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wdt_cnt_reg <= '0;
      tb_cnt_reg <= 8'h00;
    end else begin
      if (any_event || wdt_clear || halt_exec || bad_we_write ||
          we_field == `RSI_WE_DISABLE) begin
        wdt_cnt_reg <= '0;
      end else begin
        wdt_cnt_reg <= wdt_cnt_reg + CNT_W'(1);
      end
      if (reload) begin
        tb_cnt_reg <= 8'h00;
      end else begin
        tb_cnt_reg <= tb_cnt_reg + 8'h01;
      end
    end
  end

  // Software-visible control registers; a full reset reloads, sleep expiry keeps
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_control_reg <= `RSI_WDTCTL_RST;
      int_en_reg <= `RSI_INTEN_RST;
      tmr_ctl_reg <= `RSI_TMRCTL_RST;
      pdata_reg <= `RSI_PDATA_RST;
      pdir_reg <= `RSI_PDIR_RST;
      ppull_reg <= `RSI_PPULL_RST;
      pwake_reg <= `RSI_PWAKE_RST;
    end else if (reload) begin
      watchdog_control_reg <= `RSI_WDTCTL_RST;
      int_en_reg <= `RSI_INTEN_RST;
      tmr_ctl_reg <= `RSI_TMRCTL_RST;
      pdata_reg <= `RSI_PDATA_RST;
      pdir_reg <= `RSI_PDIR_RST;
      ppull_reg <= `RSI_PPULL_RST;
      pwake_reg <= `RSI_PWAKE_RST;
    end else if (reg_wr && !ev_wdt_sleep) begin
      if (hit(reg_addr, `RSI_ADDR_WDTCTL)) watchdog_control_reg <= reg_wdata;
      if (hit(reg_addr, `RSI_ADDR_INTEN)) int_en_reg <= reg_wdata;
      if (hit(reg_addr, `RSI_ADDR_TMRCTL)) tmr_ctl_reg <= reg_wdata;
      if (hit(reg_addr, `RSI_ADDR_PDATA)) pdata_reg <= reg_wdata;
      if (hit(reg_addr, `RSI_ADDR_PDIR)) pdir_reg <= reg_wdata;
      if (hit(reg_addr, `RSI_ADDR_PPULL)) ppull_reg <= reg_wdata;
      if (hit(reg_addr, `RSI_ADDR_PWAKE)) pwake_reg <= reg_wdata;
    end
  end

  // Serial registers: two pairs behind two addresses
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      serial_mode_select_reg <= 1'b0;
      serial_iface_control_reg <= `RSI_SIFCTL_RST;
      async_serial_control_reg <= `RSI_ASCTL_RST;
      serial_timeout_reg <= `RSI_SIFTO_RST;
      baud_rate_reg <= `RSI_BAUD_RST;
    end else if (reload) begin
      serial_mode_select_reg <= 1'b0;
      serial_iface_control_reg <= `RSI_SIFCTL_RST;
      async_serial_control_reg <= `RSI_ASCTL_RST;
      serial_timeout_reg <= `RSI_SIFTO_RST;
      baud_rate_reg <= `RSI_BAUD_RST;
    end else if (reg_wr && !ev_wdt_sleep) begin
      if (hit(reg_addr, `RSI_ADDR_SERMODE)) begin
        serial_mode_select_reg <= reg_wdata[`RSI_SERMODE_BIT];
      end
      if (hit(reg_addr, `RSI_ADDR_SERCTL)) begin
        if (serial_mode_select_reg) async_serial_control_reg <= reg_wdata;
        else serial_iface_control_reg <= reg_wdata;
      end
      if (hit(reg_addr, `RSI_ADDR_SERTO)) begin
        if (serial_mode_select_reg) baud_rate_reg <= reg_wdata;
        else serial_timeout_reg <= reg_wdata;
      end
    end
  end

  // Core restart request and reset-kind record
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      restart_pulse <= 1'b0;
      stack_to_top <= 1'b1;
      last_kind_reg <= RSI_KIND_POR;
    end else begin
      restart_pulse <= any_event;
      if (ev_wdt_sleep) begin
        stack_to_top <= 1'b0;
        last_kind_reg <= RSI_KIND_WDT_SLEEP;
      end else if (ev_lvr) begin
        stack_to_top <= 1'b1;
        last_kind_reg <= RSI_KIND_LVR;
      end else if (ev_wdt_run) begin
        stack_to_top <= 1'b1;
        last_kind_reg <= RSI_KIND_WDT_RUN;
      end else if (ev_soft) begin
        stack_to_top <= 1'b1;
        last_kind_reg <= RSI_KIND_SOFT;
      end
    end
  end

  // Read port: data valid in the cycle after the strobe only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        `RSI_ADDR_STATUS: reg_rdata <= 8'(({7'h00, timeout_flag_reg} << `RSI_TMO_BIT) |
                                          ({7'h00, powerdown_flag_reg} << `RSI_PWD_BIT));
        `RSI_ADDR_RSTFLAG: reg_rdata <= 8'(({7'h00, low_voltage_reset_flag_reg} << `RSI_LVF_BIT) |
                                           ({7'h00, watchdog_ctrl_reset_flag_reg} << `RSI_WCF_BIT));
        `RSI_ADDR_WDTCTL: reg_rdata <= watchdog_control_reg;
        `RSI_ADDR_INTEN: reg_rdata <= int_en_reg;
        `RSI_ADDR_TMRCTL: reg_rdata <= tmr_ctl_reg;
        `RSI_ADDR_PDATA: reg_rdata <= pdata_reg;
        `RSI_ADDR_PDIR: reg_rdata <= pdir_reg;
        `RSI_ADDR_PPULL: reg_rdata <= ppull_reg;
        `RSI_ADDR_PWAKE: reg_rdata <= pwake_reg;
        `RSI_ADDR_SERMODE: reg_rdata <= {7'h00, serial_mode_select_reg};
        `RSI_ADDR_SERCTL: reg_rdata <= serial_mode_select_reg ? async_serial_control_reg :
                                                                serial_iface_control_reg;
        `RSI_ADDR_SERTO: reg_rdata <= serial_mode_select_reg ? baud_rate_reg :
                                                               serial_timeout_reg;
        `RSI_ADDR_LASTRST: reg_rdata <= {5'h00, last_kind_reg};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // Outputs registered from the control registers and time-base counter, one cycle behind them
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      int_enable <= `RSI_INTEN_RST;
      timer_on <= 1'b0;
      port_data <= `RSI_PDATA_RST;
      port_dir <= `RSI_PDIR_RST;
      port_pull <= `RSI_PPULL_RST;
      port_wake <= `RSI_PWAKE_RST;
      time_base <= 8'h00;
    end else begin
      int_enable <= int_en_reg;
      timer_on <= tmr_ctl_reg[`RSI_TMR_ON_BIT];
      port_data <= pdata_reg;
      port_dir <= pdir_reg;
      port_pull <= ppull_reg;
      port_wake <= pwake_reg;
      time_base <= tb_cnt_reg;
    end
  end

  a_sleep_wdt_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ev_wdt_sleep |=> timeout_flag_reg && powerdown_flag_reg ##1 !stack_to_top)
    else $error("sleep expiry did not set both flags");
  a_run_wdt_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ev_wdt_run && !halt_exec && !wdt_clear |=>
      timeout_flag_reg && powerdown_flag_reg == $past(powerdown_flag_reg))
    else $error("run expiry flags wrong");
  a_lvr_keeps_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ev_lvr && !halt_exec && !wdt_clear |=> $stable(timeout_flag_reg) && $stable(powerdown_flag_reg))
    else $error("low-voltage reset changed status flags");
  a_lvr_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ev_lvr |=> low_voltage_reset_flag_reg && last_kind_reg == RSI_KIND_LVR)
    else $error("low-voltage flag not set");
  a_soft_reset_delay: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bad_we_write |-> ##[1:40] restart_pulse)
    else $error("illegal enable code did not reset in time");
  a_reload_defaults: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reload |=> watchdog_control_reg == `RSI_WDTCTL_RST && pdir_reg == `RSI_PDIR_RST &&
               int_en_reg == `RSI_INTEN_RST ##1 port_dir == `RSI_PDIR_RST)
    else $error("full reset did not reload defaults");
  a_sleep_preserve: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ev_wdt_sleep |=> $stable(watchdog_control_reg) && $stable(pdata_reg) && restart_pulse)
    else $error("sleep expiry disturbed preserved state");
  a_por_state: assert property (@(posedge clk_sys) disable iff (!rst_n)
    por_first_reg |-> !timeout_flag_reg && !powerdown_flag_reg && int_en_reg == 8'h00 &&
                      !tmr_ctl_reg[`RSI_TMR_ON_BIT] && pdata_reg == 8'hFF && stack_to_top)
    else $error("power-on state wrong");
  a_wdt_starts: assert property (@(posedge clk_sys) disable iff (!rst_n)
    por_first_reg |-> wdt_cnt_reg == '0 ##1 wdt_cnt_reg == CNT_W'(1))
    else $error("watchdog not cleared and counting after power-on");
  a_shared_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_rd && reg_addr == `RSI_ADDR_SERTO |=>
      reg_rdata == ($past(serial_mode_select_reg) ? $past(baud_rate_reg) : $past(serial_timeout_reg)))
    else $error("shared address returned wrong register");

  c_sleep_wdt: cover property (@(posedge clk_sys) disable iff (!rst_n) ev_wdt_sleep);
  c_run_wdt: cover property (@(posedge clk_sys) disable iff (!rst_n) ev_wdt_run);
  c_lvr: cover property (@(posedge clk_sys) disable iff (!rst_n) ev_lvr);
  c_soft: cover property (@(posedge clk_sys) disable iff (!rst_n) ev_soft);
endmodule : rsi_core

/* File: sim/rsi_core_model.sv */
// Core-side model: program counter and stack pointer driven by restarts
`timescale 1ns/100ps
module rsi_core_model #(
  parameter int SP_TOP = 7
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic restart_pulse,
  input wire logic stack_to_top,
  output logic [11:0] prog_counter,
  output logic [2:0] stack_ptr
);
  logic restart_seen_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prog_counter <= 12'h000;
    end else if (restart_pulse) begin
      prog_counter <= 12'h000;
    end else begin
      prog_counter <= prog_counter + 12'h001;
    end
  end
  // Stack level is taken one cycle after the restart, when it has settled
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      restart_seen_reg <= 1'b0;
      stack_ptr <= 3'(SP_TOP);
    end else begin
      restart_seen_reg <= restart_pulse;
      if (restart_seen_reg) begin
        stack_ptr <= stack_to_top ? 3'(SP_TOP) : 3'h0;
      end else if (prog_counter[3:0] == 4'hF) begin
        stack_ptr <= stack_ptr - 3'h1;
      end
    end
  end
endmodule : rsi_core_model

/* File: sim/rsi_core_tb.sv */
// Self-checking bench for the reset state initialiser
`timescale 1ns/100ps
`include "rsi_cfg.svh"
module rsi_core_tb import rsi_pkg::*; ();
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [1:0] core_mode = 2'b00;
  logic halt_exec = 1'b0;
  logic wdt_clear = 1'b0;
  logic supply_low = 1'b0;
  logic [7:0] reg_rdata, int_enable, port_data, port_dir, port_pull, port_wake, time_base;
  logic restart_pulse, stack_to_top, timer_on;
  logic [11:0] prog_counter;
  logic [2:0] stack_ptr;
  logic [7:0] vals [6];
  logic [7:0] rdv;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  localparam logic [7:0] DEF [6] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00};
  rsi_core #(.WDT_BASE_SHIFT(2), .SRESET_CYCLES(2)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .core_mode(core_mode), .halt_exec(halt_exec),
    .wdt_clear(wdt_clear), .supply_low(supply_low), .restart_pulse(restart_pulse),
    .stack_to_top(stack_to_top), .int_enable(int_enable), .timer_on(timer_on),
    .port_data(port_data), .port_dir(port_dir), .port_pull(port_pull),
    .port_wake(port_wake), .time_base(time_base));
  rsi_core_model #(.SP_TOP(7)) core (.clk_sys(clk_sys), .rst_n(rst_n),
    .restart_pulse(restart_pulse), .stack_to_top(stack_to_top),
    .prog_counter(prog_counter), .stack_ptr(stack_ptr));
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      final_report();
    end
  end
  function automatic logic [7:0] status_exp(input logic tmo, input logic pd);
    return {2'b00, tmo, pd, 4'h0};
  endfunction : status_exp
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count = check_count + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, string s);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    chk(s, e & m, reg_rdata & m);
  endtask : rd
  // One-cycle pulse of halt (h=1) or watchdog clear (h=0)
  task automatic pulse(input logic h);
    @(posedge clk_sys);
    halt_exec <= h;
    wdt_clear <= ~h;
    @(posedge clk_sys);
    halt_exec <= 1'b0;
    wdt_clear <= 1'b0;
  endtask : pulse
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    chk("time_base", 8'h00, time_base);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("time_base run", 8'h01, time_base);
  endtask : do_reset
  task automatic wait_restart(input int limit, input logic top);
    int n;
    n = 0;
    @(posedge clk_sys);
    while (restart_pulse !== 1'b1 && n < limit) begin
      @(posedge clk_sys);
      n = n + 1;
    end
    chk("restart", 8'h01, {7'h0, restart_pulse});
    @(posedge clk_sys);
    chk("pc", 8'h00, prog_counter[7:0]);
    @(posedge clk_sys);
    chk("sp", top ? 8'h07 : 8'h00, {5'h0, stack_ptr});
  endtask : wait_restart
  task automatic load_rand();
    for (int i = 0; i < 6; i++) begin
      vals[i] = 8'($urandom);
      wr(8'(`RSI_ADDR_INTEN + i), vals[i]);
    end
  endtask : load_rand
  task automatic chk_regs(input logic [7:0] e [6]);
    for (int i = 0; i < 6; i++) begin
      rd(8'(`RSI_ADDR_INTEN + i), 8'hFF, e[i], "reg");
    end
    chk("int_enable", e[0], int_enable);
    chk("timer_on", {7'h0, e[1][3]}, {7'h0, timer_on});
    chk("port_data", e[2], port_data);
    chk("port_dir", e[3], port_dir);
    chk("port_pull", e[4], port_pull);
    chk("port_wake", e[5], port_wake);
  endtask : chk_regs
  initial begin
    void'($urandom(87256));
    do_reset();
    rd(`RSI_ADDR_WDTCTL, 8'hFF, 8'h53, "wdtctl");
    wr(`RSI_ADDR_WDTCTL, 8'hAB);
    rd(`RSI_ADDR_STATUS, 8'h30, 8'h00, "status");
    rd(8'hF0, 8'hFF, 8'h00, "unmapped");
    chk_regs(DEF);
    $display("test power_on done");
    rd(`RSI_ADDR_SERCTL, 8'hFF, 8'h81, "serctl");
    rd(`RSI_ADDR_SERTO, 8'hFF, 8'h00, "serto");
    wr(`RSI_ADDR_SERMODE, 8'h01);
    rd(`RSI_ADDR_SERCTL, 8'hFF, 8'h00, "asctl");
    rdv = 8'($urandom) | 8'h01;
    wr(`RSI_ADDR_SERTO, rdv);
    rd(`RSI_ADDR_SERTO, 8'hFF, rdv, "baud");
    wr(`RSI_ADDR_SERMODE, 8'h00);
    rd(`RSI_ADDR_SERTO, 8'hFF, 8'h00, "serto back");
    wr(`RSI_ADDR_SERCTL, rdv);
    rd(`RSI_ADDR_SERCTL, 8'hFF, rdv, "sifctl");
    $display("test serial_share done");
    load_rand();
    chk_regs(vals);
    core_mode <= 2'($urandom % 2);
    pulse(1'b1);
    wr(`RSI_ADDR_WDTCTL, 8'h53);
    wait_restart(40, 1'b1);
    wr(`RSI_ADDR_WDTCTL, 8'hAB);
    rd(`RSI_ADDR_STATUS, 8'h30, status_exp(1'b1, 1'b1), "status run");
    rd(`RSI_ADDR_LASTRST, 8'hFF, 8'h02, "lastrst run");
    chk_regs(DEF);
    rd(`RSI_ADDR_SERCTL, 8'hFF, 8'h81, "sifctl reload");
    pulse(1'b0);
    $display("test wdt_run done");
    load_rand();
    core_mode <= 2'h2 | 2'($urandom % 2);
    pulse(1'b1);
    wr(`RSI_ADDR_WDTCTL, 8'h53);
    wait_restart(40, 1'b0);
    wr(`RSI_ADDR_WDTCTL, 8'hAB);
    core_mode <= RSI_MODE_FAST;
    rd(`RSI_ADDR_STATUS, 8'h30, status_exp(1'b1, 1'b1), "status sleep");
    chk_regs(vals);
    $display("test wdt_sleep done");
    pulse(1'b0);
    pulse(1'b1);
    supply_low <= 1'b1;
    wait_restart(10, 1'b1);
    wr(`RSI_ADDR_WDTCTL, 8'hAB);
    supply_low <= 1'b0;
    rd(`RSI_ADDR_STATUS, 8'h30, status_exp(1'b0, 1'b1), "status lvr");
    rd(`RSI_ADDR_RSTFLAG, 8'h05, 8'h04, "lvr flag");
    wr(`RSI_ADDR_RSTFLAG, 8'h00);
    rd(`RSI_ADDR_RSTFLAG, 8'h05, 8'h00, "lvr flag clr");
    $display("test low_voltage done");
    wr(`RSI_ADDR_WDTCTL, 8'hFF);
    wait_restart(8, 1'b1);
    wr(`RSI_ADDR_WDTCTL, 8'hAB);
    rd(`RSI_ADDR_RSTFLAG, 8'h05, 8'h01, "wdtctl flag");
    rd(`RSI_ADDR_LASTRST, 8'hFF, 8'h04, "lastrst soft");
    wr(`RSI_ADDR_RSTFLAG, 8'h00);
    rd(`RSI_ADDR_RSTFLAG, 8'h05, 8'h00, "wdtctl flag clr");
    $display("test bad_enable done");
    supply_low <= 1'b1;
    fork
      do_reset();
      begin
        repeat (2) @(posedge clk_sys);
        supply_low <= 1'b0;
      end
    join
    rd(`RSI_ADDR_STATUS, 8'h30, 8'h00, "status por");
    rd(`RSI_ADDR_LASTRST, 8'hFF, 8'h00, "lastrst por");
    wait_restart(40, 1'b1);
    $display("test second_por done");
    final_report();
  end
endmodule : rsi_core_tb
